// [pkg/spi_fb_access_defines.vh]
/*
 * Constants of the SPI register and frame buffer access block: register
 * offsets, field positions, reset values and buffer sizes.
 * Assumes inclusion by bare name from the design files under hw/.
 */
`ifndef SPI_FB_ACCESS_DEFINES_VH
`define SPI_FB_ACCESS_DEFINES_VH

// Register map, 6-bit address space
`define REG_ADDR_W 6
`define REG_COUNT 64
`define REG_CTRL_ONE 6'h04
`define REG_TRX_STATE 6'h01
`define REG_SIG_STRENGTH 6'h06
`define REG_IRQ_FLAGS 6'h0f
`define CTRL_ONE_RESET 8'h22
`define CTRL_SRC_HI 3
`define CTRL_SRC_LO 2

// Status byte source codes
`define SRC_ZERO 2'h0
`define SRC_TRX_STATE 2'h1
`define SRC_SIG_STRENGTH 2'h2
`define SRC_IRQ_FLAGS 2'h3
`define STATUS_RESET 8'h00

// Command byte fields
`define CMD_REG_BIT 7
`define CMD_WR_BIT 6
`define CMD_FB_RD 3'h1
`define CMD_FB_WR 3'h3

// Frame buffer
`define FB_DEPTH 128
`define FB_ADDR_W 8
`define FB_MAX_LEN 7'h7f
`define FB_ADDR_END 8'hff

// Received frame status byte layout
`define RXS_CRC_BIT 7
`define RXS_RESULT_HI 6
`define RXS_RESULT_LO 4
`define RXS_RESET 8'h00

// Receive stream FIFO
`define RX_FIFO_DEPTH 32
`define RX_FIFO_WIDTH 9

`endif

// [hw/spi_fb_access.v]
/*
 * SPI slave access logic: command decode, register access over a 64-entry
 * register space and frame buffer streaming, plus the receive FIFO that
 * fills the frame buffer from the radio side.
 * Assumes one 10 MHz clock with synchronous active-high reset; the SPI pins
 * come from another domain and are oversampled, SCLK well below clk/4.
 */
// Overview of operation
// - First MISO byte is the status byte, zero after reset, chosen by ctrl.
// - Register access covers addresses 0x00 to 0x3F by a six-bit field.
// - Register command: bit7 one, bit6 read/write, low six bits address.
// - Register read returns the addressed register in the second byte.
// - Register write stores the second MOSI byte; MISO then is don't-care.
// - Frame buffer access restarts buffer address at zero, then increments.
// - Frame buffer holds up to 128 bytes.
// - Command byte is followed by length header, then payload bytes.
// - Read ends with link quality, energy level and frame status bytes.
// - Frame status: checksum valid bit 7, result bits 6..4, rest zero.
// - Length at most 127; read spans 132 bytes, write 129 at most.
// - Buffer address advances after every data byte until select rises, holding at 0xFF.
// - Aborting a frame read at any byte has no side effect.
// - Each new frame read starts again with the length header.
// - Buffer replaced by a newly received frame or a frame write.
// - Top bits: 10 reg read, 11 reg write, 001 fb read, 011 fb write.
// - Mode 0, MSB first, sample on rise, change on fall, eight clocks.
// - Status source 0 zeros, 1 state, 2 signal strength, 3 irq flags.
`timescale 1ns/1ps
`include "spi_fb_access_defines.vh"

module rx_stream_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output reg in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push, pop;
    reg [AW:0] nxt_count;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_ff];

    always @* begin
        nxt_count = count_ff;
        if (push && !pop)
            nxt_count = count_ff + 1'b1;
        else if (pop && !push)
            nxt_count = count_ff - 1'b1;
    end

    always @(posedge clk) begin
        if (push)
            mem[wr_ptr_ff] <= in_data;
    end

    // Registered ready so the source sees full one cycle early at most
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            count_ff <= nxt_count;
            in_ready <= (nxt_count < DEPTH[AW:0]);
        end
    end
endmodule

module spi_fb_access #(
    parameter FB_DEPTH = `FB_DEPTH,
    parameter FIFO_DEPTH = `RX_FIFO_DEPTH
) (
    input wire clk,
    input wire rst,
    input wire sel_n,
    input wire sclk,
    input wire mosi,
    output reg miso,
    output reg miso_oe,
    input wire [7:0] transceiver_state_reg,
    input wire [7:0] signal_strength_reg,
    input wire [7:0] irq_flag_reg,
    input wire [7:0] rx_byte,
    input wire rx_byte_last,
    input wire rx_byte_valid,
    output wire rx_byte_ready,
    input wire [7:0] rx_link_quality,
    input wire [7:0] rx_energy_level,
    input wire rx_crc_valid,
    input wire [2:0] rx_transaction_result,
    output reg [7:0] transceiver_control_one
);
    localparam ST_IDLE = 6'h01;
    localparam ST_CMD = 6'h02;
    localparam ST_REG_RD = 6'h04;
    localparam ST_REG_WR = 6'h08;
    localparam ST_FB_RD = 6'h10;
    localparam ST_FB_WR = 6'h20;

    reg [2:0] sel_sync_ff;
    reg [2:0] sclk_sync_ff;
    reg [1:0] mosi_sync_ff;
    reg [5:0] state_ff;
    reg [2:0] bit_cnt_ff;
    reg [7:0] rx_sr_ff, tx_sr_ff;
    reg [5:0] reg_addr_ff;
    reg [`FB_ADDR_W-1:0] fb_addr_ff;
    reg [7:0] regs [0:`REG_COUNT-1];
    reg [7:0] fb_mem [0:FB_DEPTH-1];
    reg [6:0] rx_ptr_ff;
    reg [7:0] lq_ff, energy_ff, rx_frame_status_byte;
    reg [7:0] status_byte, reg_rd_data, fb_rd_data, nxt_tx;
    reg [5:0] nxt_state;
    wire sel_fall, sel_high, sclk_rise, sclk_fall;
    wire [7:0] byte_in;
    wire byte_done;
    wire [6:0] fb_len;
    wire [`FB_ADDR_W-1:0] len_ext;
    wire fb_session;
    wire [8:0] fifo_out;
    wire fifo_valid, drain;
    integer i;

    assign sel_high = sel_sync_ff[1];
    assign sel_fall = !sel_sync_ff[1] && sel_sync_ff[2];
    assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];
    assign sclk_fall = !sclk_sync_ff[1] && sclk_sync_ff[2];
    assign byte_in = {rx_sr_ff[6:0], mosi_sync_ff[1]};
    assign byte_done = sclk_rise && (bit_cnt_ff == 3'h7) && !sel_high;
    assign fb_len = fb_mem[0][6:0];
    assign len_ext = {1'b0, fb_len};
    assign fb_session = (state_ff == ST_FB_RD) || (state_ff == ST_FB_WR);
    // Radio writes pause while the master streams the buffer
    assign drain = fifo_valid && !fb_session;

    rx_stream_fifo #(
        .WIDTH(`RX_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(5)
    ) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .in_data({rx_byte_last, rx_byte}),
        .in_valid(rx_byte_valid),
        .in_ready(rx_byte_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(drain)
    );

    always @* begin
        case (transceiver_control_one[`CTRL_SRC_HI:`CTRL_SRC_LO])
            `SRC_TRX_STATE: status_byte = transceiver_state_reg;
            `SRC_SIG_STRENGTH: status_byte = signal_strength_reg;
            `SRC_IRQ_FLAGS: status_byte = irq_flag_reg;
            default: status_byte = `STATUS_RESET;
        endcase
    end

    always @* begin
        case (byte_in[5:0])
            `REG_CTRL_ONE: reg_rd_data = transceiver_control_one;
            `REG_TRX_STATE: reg_rd_data = transceiver_state_reg;
            `REG_SIG_STRENGTH: reg_rd_data = signal_strength_reg;
            `REG_IRQ_FLAGS: reg_rd_data = irq_flag_reg;
            default: reg_rd_data = regs[byte_in[5:0]];
        endcase
    end

    // Header, payload, then the three trailing bytes
    always @* begin
        if (fb_addr_ff <= len_ext)
            fb_rd_data = fb_mem[fb_addr_ff[6:0]];
        else if (fb_addr_ff == len_ext + 8'h01)
            fb_rd_data = lq_ff;
        else if (fb_addr_ff == len_ext + 8'h02)
            fb_rd_data = energy_ff;
        else if (fb_addr_ff == len_ext + 8'h03)
            fb_rd_data = rx_frame_status_byte;
        else
            fb_rd_data = 8'h00;
    end

    always @* begin
        nxt_tx = 8'h00;
        nxt_state = state_ff;
        case (state_ff)
            ST_CMD: begin
                if (byte_in[`CMD_REG_BIT]) begin
                    if (byte_in[`CMD_WR_BIT]) begin
                        nxt_state = ST_REG_WR;
                    end else begin
                        nxt_state = ST_REG_RD;
                        nxt_tx = reg_rd_data;
                    end
                end else if (byte_in[7:5] == `CMD_FB_RD) begin
                    nxt_state = ST_FB_RD;
                    nxt_tx = fb_mem[0];
                end else if (byte_in[7:5] == `CMD_FB_WR) begin
                    nxt_state = ST_FB_WR;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_REG_RD: nxt_state = ST_IDLE;
            ST_REG_WR: nxt_state = ST_IDLE;
            ST_FB_RD: nxt_tx = fb_rd_data;
            ST_FB_WR: nxt_tx = 8'h00;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Pin inputs cross on two flops; edges read stages one and two only
    always @(posedge clk) begin
        if (rst) begin
            sel_sync_ff <= 3'h7;
            sclk_sync_ff <= 3'h0;
            mosi_sync_ff <= 2'h0;
        end else begin
            sel_sync_ff <= {sel_sync_ff[1:0], sel_n};
            sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
            mosi_sync_ff <= {mosi_sync_ff[0], mosi};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 3'h0;
            rx_sr_ff <= 8'h00;
            tx_sr_ff <= 8'h00;
            miso <= 1'b0;
            miso_oe <= 1'b0;
            reg_addr_ff <= 6'h00;
            fb_addr_ff <= {`FB_ADDR_W{1'b0}};
        end else if (sel_high) begin
            state_ff <= ST_IDLE;
            miso_oe <= 1'b0;
            bit_cnt_ff <= 3'h0;
        end else if (sel_fall) begin
            state_ff <= ST_CMD;
            miso_oe <= 1'b1;
            miso <= status_byte[7];
            tx_sr_ff <= {status_byte[6:0], 1'b0};
            bit_cnt_ff <= 3'h0;
        end else begin
            if (sclk_rise) begin
                rx_sr_ff <= byte_in;
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (sclk_fall) begin
                miso <= tx_sr_ff[7];
                tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
            end
            if (byte_done) begin
                state_ff <= nxt_state;
                tx_sr_ff <= nxt_tx;
                if (state_ff == ST_CMD) begin
                    reg_addr_ff <= byte_in[5:0];
                    fb_addr_ff <= (nxt_state == ST_FB_RD) ?
                        8'h01 : 8'h00;
                end else if (fb_session &&
                    fb_addr_ff != `FB_ADDR_END) begin
                    fb_addr_ff <= fb_addr_ff + 8'h01;
                end
            end
        end
    end

    // Plain register space; mirrored registers are served from inputs and transceiver_control_one
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < `REG_COUNT; i = i + 1)
                regs[i] <= 8'h00;
            transceiver_control_one <= `CTRL_ONE_RESET;
        end else if (byte_done && state_ff == ST_REG_WR) begin
            regs[reg_addr_ff] <= byte_in;
            if (reg_addr_ff == `REG_CTRL_ONE)
                transceiver_control_one <= byte_in;
        end
    end

    // Frame buffer: master writes and radio frames share one port
    always @(posedge clk) begin
        if (byte_done && state_ff == ST_FB_WR &&
            fb_addr_ff < FB_DEPTH) begin
            if (fb_addr_ff == 8'h00)
                fb_mem[0] <= {1'b0, byte_in[6:0]};
            else
                fb_mem[fb_addr_ff[6:0]] <= byte_in;
        end else if (drain) begin
            fb_mem[rx_ptr_ff] <= fifo_out[7:0];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rx_ptr_ff <= 7'h00;
            lq_ff <= 8'h00;
            energy_ff <= 8'h00;
            rx_frame_status_byte <= `RXS_RESET;
        end else if (drain) begin
            if (fifo_out[8]) begin
                rx_ptr_ff <= 7'h00;
                lq_ff <= rx_link_quality;
                energy_ff <= rx_energy_level;
                rx_frame_status_byte <= {rx_crc_valid,
                    rx_transaction_result, 4'h0};
            end else if (rx_ptr_ff != `FB_MAX_LEN) begin
                rx_ptr_ff <= rx_ptr_ff + 7'h01;
            end
        end
    end
endmodule

// [verification/spi_fb_access_props.sv]
/* Port checker for spi_fb_access.
   Assumes bind to the top module and the design header on the path. */
`timescale 1ns/1ps
`include "spi_fb_access_defines.vh"
module spi_fb_access_props (
    input wire clk,
    input wire rst,
    input wire sel_n,
    input wire sclk,
    input wire miso,
    input wire miso_oe,
    input wire [7:0] transceiver_state_reg,
    input wire [7:0] signal_strength_reg,
    input wire [7:0] irq_flag_reg,
    input wire rx_byte_ready,
    input wire [7:0] transceiver_control_one
);
    wire [1:0] src = transceiver_control_one[3:2];
    wire st7 = src == 2'h0 ? 1'b0 : src == 2'h1 ? transceiver_state_reg[7] :
        src == 2'h2 ? signal_strength_reg[7] : irq_flag_reg[7];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst_out;
        $fell(rst) |-> !miso_oe && !miso;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("pins busy at reset");
    property p_ctrl_rst;
        $fell(rst) |-> transceiver_control_one == `CTRL_ONE_RESET;
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst) else $error("ctrl reset");
    property p_oe_on;
        (!sel_n)[*5] |-> miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("driver off");
    property p_oe_off;
        sel_n[*5] |-> !miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver on");
    property p_miso_hold;
        sclk[*4] |-> $stable(miso);
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved");
    property p_status;
        $rose(miso_oe) |-> ##1 (miso == st7)[*3];
    endproperty
    a_status: assert property (p_status) else $error("status msb");
    property p_ctrl_sel;
        $changed(transceiver_control_one) |-> !$past(sel_n, 4);
    endproperty
    a_ctrl_sel: assert property (p_ctrl_sel) else $error("ctrl write");
    property p_ready_rst;
        $fell(rst) |-> ##[0:2] rx_byte_ready;
    endproperty
    a_ready_rst: assert property (p_ready_rst) else $error("no ready");
endmodule
bind spi_fb_access spi_fb_access_props chk_u (.clk(clk), .rst(rst),
    .sel_n(sel_n), .sclk(sclk), .miso(miso), .miso_oe(miso_oe),
    .transceiver_state_reg(transceiver_state_reg),
    .signal_strength_reg(signal_strength_reg), .irq_flag_reg(irq_flag_reg),
    .rx_byte_ready(rx_byte_ready),
    .transceiver_control_one(transceiver_control_one));

// [verification/spi_master_model.sv]
/* SPI mode 0 master standing in for the host controller.
   Assumes clk is the design clock; sclk half period is four cycles. */
`timescale 1ns/1ps
module spi_master_model (
    input wire clk,
    input wire miso,
    input wire miso_oe,
    output reg sel_n,
    output reg sclk,
    output reg mosi
);
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task automatic start();
        @(negedge clk);
        sel_n = 1'b0;
    endtask
    task automatic xfer(input [7:0] tx, output [7:0] rx);
        int i;
        for (i = 7; i >= 0; i--) begin
            mosi = tx[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            // Released line reads as the inverted miso value, not the last bit
            rx[i] = miso_oe ? miso : ~miso;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
    endtask
    task automatic stop();
        repeat (4) @(negedge clk);
        sel_n = 1'b1;
        mosi = ~mosi;
        repeat (8) @(negedge clk);
    endtask
endmodule

// [verification/tb_spi_fb_access.sv]
/* Self-checking bench for spi_fb_access with a SPI master model.
   Assumes the design header on the include path. */
`timescale 1ns/1ps
`include "spi_fb_access_defines.vh"
module tb_spi_fb_access;
    reg clk, rst, lst, vld, crc;
    reg [7:0] tsr, ssr, ifr, rxb, lq, nrg;
    reg [2:0] res;
    reg [1:0] src;
    reg [7:0] frm [0:127];
    wire sel_n, sclk, mosi, miso, oe, rdy;
    wire [7:0] tco;
    int n_errors = 0, total_checks = 0, fi;
    spi_fb_access dut_u (.clk(clk), .rst(rst), .sel_n(sel_n), .sclk(sclk),
        .mosi(mosi), .miso(miso), .miso_oe(oe), .transceiver_state_reg(tsr),
        .signal_strength_reg(ssr), .irq_flag_reg(ifr), .rx_byte(rxb),
        .rx_byte_last(lst), .rx_byte_valid(vld), .rx_byte_ready(rdy),
        .rx_link_quality(lq), .rx_energy_level(nrg), .rx_crc_valid(crc),
        .rx_transaction_result(res), .transceiver_control_one(tco));
    spi_master_model m_u (.clk(clk), .miso(miso), .miso_oe(oe),
        .sel_n(sel_n), .sclk(sclk), .mosi(mosi));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input [7:0] got, input [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic [7:0] stat();
        case (src)
            2'h0: return 8'h00;
            2'h1: return tsr;
            2'h2: return ssr;
            default: return ifr;
        endcase
    endfunction
    function automatic [7:0] fbx(input int k);
        if (k <= frm[0]) return frm[k];
        if (k == frm[0] + 1) return lq;
        if (k == frm[0] + 2) return nrg;
        return {crc, res, 4'h0};
    endfunction
    task automatic open_cmd(input [7:0] cmd);
        reg [7:0] s;
        m_u.start();
        m_u.xfer(cmd, s);
        check(s, stat());
    endtask
    task automatic reg_acc(input [7:0] cmd, input [7:0] wd, output [7:0] r);
        open_cmd(cmd);
        m_u.xfer(wd, r);
        m_u.stop();
    endtask
    task automatic fb_read(input int n);
        reg [7:0] r;
        int k;
        open_cmd({3'b001, 5'($urandom)});
        for (k = 0; k < n; k++) begin
            m_u.xfer(8'($urandom), r);
            check(r, fbx(k));
        end
        m_u.stop();
    endtask
    task automatic new_frame(input int len);
        int k;
        frm[0] = 8'(len);
        for (k = 1; k <= len; k++) frm[k] = 8'($urandom);
        fi = 0;
    endtask
    // Valid held across cycles; the byte advances only on acceptance
    task automatic feed(input int bound, input bit must);
        int t;
        reg acc;
        for (t = 0; t < bound && fi <= frm[0]; t++) begin
            @(negedge clk);
            vld = 1'b1;
            rxb = frm[fi];
            lst = fi == frm[0];
            // Ready is taken before the edge it qualifies, not after
            acc = rdy;
            @(posedge clk);
            if (acc === 1'b1) fi++;
        end
        @(negedge clk);
        vld = 1'b0;
        if (must && fi <= frm[0]) begin
            n_errors++;
            $display("unexpected at %0t: receive feed timed out", $time);
            finish_test();
        end
    endtask
    initial begin : main
        int k, len;
        reg [7:0] r, d;
        reg [5:0] a;
        rst = 1'b1;
        vld = 1'b0;
        lst = 1'b0;
        rxb = 8'h00;
        src = 2'h0;
        {tsr, ssr, ifr, lq, nrg, crc, res} = '0;
        k = $urandom(21678);
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        reg_acc({2'b10, `REG_CTRL_ONE}, 8'h00, r);
        check(r, `CTRL_ONE_RESET);
        for (k = 0; k < 4; k++) begin
            {tsr, ssr, ifr} = 24'($urandom);
            d = (`CTRL_ONE_RESET & 8'hf3) | 8'(k << 2);
            reg_acc({2'b11, `REG_CTRL_ONE}, d, r);
            check(tco, d);
            src = k[1:0];
            reg_acc({2'b10, `REG_TRX_STATE}, 8'h00, r);
            check(r, tsr);
        end
        reg_acc({2'b10, `REG_SIG_STRENGTH}, 8'h00, r);
        check(r, ssr);
        reg_acc({2'b10, `REG_IRQ_FLAGS}, 8'h00, r);
        check(r, ifr);
        for (k = 0; k < 6; k++) begin
            do a = k == 0 ? 6'h00 : k == 1 ? 6'h3f : 6'($urandom);
            while (a == `REG_TRX_STATE || a == `REG_CTRL_ONE ||
                a == `REG_SIG_STRENGTH || a == `REG_IRQ_FLAGS);
            d = 8'($urandom);
            reg_acc({2'b11, a}, d, r);
            reg_acc({2'b10, a}, 8'($urandom), r);
            check(r, d);
        end
        for (k = 0; k < 2; k++) begin
            reg_acc({1'b0, k[0], 1'b0, 5'($urandom)}, 8'($urandom), r);
            check(r, 8'h00);
        end
        {lq, nrg, crc, res} = 20'($urandom);
        len = 40 + $urandom % 88;
        new_frame(len);
        feed(5000, 1'b1);
        // Drain time for the FIFO into the buffer
        repeat (200) @(negedge clk);
        fb_read(2);
        fb_read(len + 4);
        {lq, nrg, crc, res} = 20'($urandom);
        new_frame(127);
        open_cmd({3'b001, 5'($urandom)});
        feed(60, 1'b0);
        check(8'(fi), 8'(`RX_FIFO_DEPTH));
        check({7'h00, rdy}, 8'h00);
        m_u.stop();
        feed(5000, 1'b1);
        repeat (200) @(negedge clk);
        fb_read(131);
        new_frame(1 + $urandom % 127);
        open_cmd({3'b011, 5'($urandom)});
        m_u.xfer({1'b1, frm[0][6:0]}, r);
        for (k = 1; k <= frm[0]; k++) m_u.xfer(frm[k], r);
        m_u.stop();
        fb_read(frm[0] + 4);
        finish_test();
    end
endmodule
